// >>> bench/framer_sva.sv
// port assertions for the tension message framer
`timescale 1ns/1ps
module framer_sva
    import tension_framer_pkg::*;
(
    // clock and reset
    input wire logic                   ref_clk,
    input wire logic                   resetn,
    // record access
    input wire logic                   cfg_wr,
    input wire logic                   cfg_rd,
    input wire logic [3:0]             cfg_addr,
    input wire logic [7:0]             cfg_wdata,
    input wire logic [7:0]             cfg_rdata_q,
    input wire logic                   cfg_rvalid_q,
    input wire logic [RANGE_TOP_W-1:0] range_top_q,
    input wire logic [7:0]             stop_filter_q,
    // seams and stream
    input wire logic                   seam_done,
    input wire seam_result_s           seam_result,
    input wire event_msg_s             event_msg_q,
    input wire logic [7:0]             tx_data_q,
    input wire logic                   tx_valid_q,
    input wire logic                   tx_ready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    range_clamp_a: assert property (
        (cfg_wr && cfg_addr == 4'he && cfg_wdata[4:0] > 5'h0c) ##1 !(cfg_wr && cfg_addr == 4'he)
        |=> range_top_q == 12'd1536) else $error("range not clamped");
    range_scale_a: assert property (
        (cfg_wr && cfg_addr == 4'he && cfg_wdata[4:0] <= 5'h0c) ##1 !(cfg_wr && cfg_addr == 4'he)
        |=> range_top_q == {$past(cfg_wdata[4:0], 2), 7'h00}) else $error("range top wrong");
    range_readback_a: assert property (
        (cfg_wr && cfg_addr == 4'he) ##1 !cfg_wr ##1 (cfg_rd && !cfg_wr && cfg_addr == 4'he)
        |=> cfg_rvalid_q && cfg_rdata_q == $past(cfg_wdata, 3)) else $error("range readback wrong");
    msg_sum_a: assert property (
        8'(event_msg_q.flags_tension_high + event_msg_q.tension_low + event_msg_q.checksum) == 8'h00)
        else $error("message sum not zero");
    msg_tension_a: assert property (
        seam_done |=> event_msg_q.tension_low == $past(seam_result.tension[7:0])
        && event_msg_q.flags_tension_high[3:0] == $past(seam_result.tension[11:8])) else $error("tension bits wrong");
    ind_flags_a: assert property (
        seam_done |=> event_msg_q.flags_tension_high[7:6] == $past({seam_result.above_ind, seam_result.below_ind}))
        else $error("indication flags wrong");
    stop_off_a: assert property (
        seam_done && stop_filter_q == 8'h00 && $past(stop_filter_q) == 8'h00
        |=> event_msg_q.flags_tension_high[5:4] == 2'b00) else $error("stop flags not filtered");
    reset_msg_a: assert property (
        $rose(resetn) |-> event_msg_q == '0) else $error("message not zero after reset");
    tx_hold_a: assert property (
        tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q)) else $error("stream byte dropped");
    frame_end_a: assert property (
        (tx_valid_q && tx_ready) [*3] |=> !tx_valid_q) else $error("frame longer than three");
endmodule

bind tension_monitor_message_framer framer_sva u_sva (.ref_clk, .resetn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
    .cfg_rdata_q, .cfg_rvalid_q, .range_top_q, .stop_filter_q, .seam_done, .seam_result, .event_msg_q,
    .tx_data_q, .tx_valid_q, .tx_ready);

// >>> bench/host_receiver.sv
// host side receiver of event message frames
`timescale 1ns/1ps
module host_receiver (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // event stream
    input  wire logic [7:0] tx_data_q,
    input  wire logic       tx_valid_q,
    output logic            tx_ready,
    // bench control and results
    input  wire logic       stall,
    output logic [23:0]     last_frame,
    output int              bad_cnt
);
    logic [1:0]  idx;
    logic [15:0] part;
    assign tx_ready = !stall;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idx <= 2'd0;
            part <= 16'h0000;
            last_frame <= 24'h000000;
            bad_cnt <= 0;
        end else if (tx_valid_q && tx_ready) begin
            if (idx == 2'd2) begin
                last_frame <= {part, tx_data_q};
                if (8'(part[15:8] + part[7:0] + tx_data_q) != 8'h00) bad_cnt <= bad_cnt + 1;
                idx <= 2'd0;
            end else begin
                part <= {part[7:0], tx_data_q};
                idx <= idx + 2'd1;
            end
        end
    end
endmodule

// >>> bench/tb.sv
// self-checking bench for the tension message framer
`timescale 1ns/1ps
module tb;
    import tension_framer_pkg::*;
    logic         ref_clk = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0, seam_done = 0, stall = 0;
    logic [3:0]   cfg_addr = 4'h0;
    logic [7:0]   cfg_wdata = 8'h00, head_sum = 8'h00;
    seam_result_s seam_result = '0;
    logic [7:0]   cfg_rdata_q, stop_filter_q, cfg_sum_expect_q, tx_data_q, ex;
    logic         cfg_rvalid_q, cfg_sum_ok_q, tx_valid_q, tx_ready;
    logic [11:0]  range_top_q;
    event_msg_s   event_msg_q;
    logic [23:0]  last_frame;
    int           bad_cnt, err_total = 0, cmp_count = 0;

    always #2 ref_clk = ~ref_clk;

    tension_monitor_message_framer DUT (.ref_clk, .resetn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata_q,
        .cfg_rvalid_q, .head_sum, .cfg_sum_ok_q, .cfg_sum_expect_q, .range_top_q, .stop_filter_q, .seam_done,
        .seam_result, .event_msg_q, .tx_data_q, .tx_valid_q, .tx_ready);
    host_receiver u_host (.ref_clk, .resetn, .tx_data_q, .tx_valid_q, .tx_ready, .stall, .last_frame, .bad_cnt);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        cfg_wr = 1;
        cfg_addr = a;
        cfg_wdata = d;
        tick();
        cfg_wr = 0;
        tick();
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] exp);
        cfg_rd = 1;
        cfg_addr = a;
        tick();
        cfg_rd = 0;
        chk("rvalid", 24'h1, {23'h0, cfg_rvalid_q});
        chk("rdata", {16'h0, exp}, {16'h0, cfg_rdata_q});
        tick();
    endtask
    task automatic seam(logic [11:0] t, logic [3:0] f);
        seam_result = {t, f};
        seam_done = 1;
        tick();
        seam_done = 0;
        tick();
    endtask
    function automatic logic [23:0] msg(logic [7:0] b1, logic [7:0] b2);
        return {b1, b2, 8'(8'h00 - b1 - b2)};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        chk("event_msg", 24'h0, event_msg_q);
        rd(4'hc, 8'h00);
        chk("range_top", 24'd640, {12'h0, range_top_q});
        rd(4'hd, 8'h01);
        rd(4'he, 8'h05);
        rd(4'hf, 8'hfb);
        wr(4'h3, 8'h55);
        rd(4'h3, 8'h00);
    endtask
    task automatic test_range();
        logic [7:0] v [6] = '{8'h00, 8'h01, 8'h0c, 8'h0d, 8'h1f, 8'he7};
        foreach (v[i]) begin
            wr(4'he, v[i]);
            tick();
            tick();
            chk("range_top", (v[i][4:0] > 5'h0c ? 24'd12 : {19'h0, v[i][4:0]}) * 24'd128, {12'h0, range_top_q});
            rd(4'he, v[i]);
        end
        wr(4'he, 8'h1f);
        rd(4'he, 8'h1f);
        wr(4'he, 8'h05);
    endtask
    task automatic test_record_sum();
        head_sum = 8'h3c;
        wr(4'hc, 8'h5a);
        wr(4'hd, 8'h02);
        wr(4'he, 8'h07);
        tick();
        tick();
        ex = 8'h00 - 8'h3c - 8'h5a - 8'h02 - 8'h07;
        chk("sum_expect", {16'h0, ex}, {16'h0, cfg_sum_expect_q});
        chk("stop_filter", 24'h2, {16'h0, stop_filter_q});
        wr(4'hf, ex);
        tick();
        tick();
        chk("sum_ok", 24'h1, {23'h0, cfg_sum_ok_q});
        wr(4'hf, ex + 8'h01);
        tick();
        tick();
        chk("sum_ok", 24'h0, {23'h0, cfg_sum_ok_q});
    endtask
    task automatic test_seams();
        stall = 1;
        seam(12'habc, 4'b1001);
        chk("event_msg", msg(8'h8a, 8'hbc), event_msg_q);
        seam(12'h123, 4'b1010);
        chk("event_msg", msg(8'h51, 8'h23), event_msg_q);
        seam(12'hfff, 4'b0100);
        chk("event_msg", msg(8'h0f, 8'hff), event_msg_q);
        seam(12'hfff, 4'b0100);
        chk("event_msg", msg(8'h2f, 8'hff), event_msg_q);
        seam(12'h456, 4'b0010);
        chk("event_msg", msg(8'h44, 8'h56), event_msg_q);
        repeat (6) tick();
        stall = 0;
        repeat (30) tick();
        chk("last_frame", msg(8'h44, 8'h56), last_frame);
        chk("bad_frames", 24'h0, bad_cnt[23:0]);
        wr(4'hd, 8'h00);
        repeat (3) tick();
        seam(12'h000, 4'b1100);
        chk("event_msg", 24'h0, event_msg_q);
        seam(12'h800, 4'b1100);
        chk("event_msg", msg(8'h08, 8'h00), event_msg_q);
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        resetn = 1;
        test_reset();
        test_range();
        test_record_sum();
        test_seams();
        give_verdict();
    end

    initial begin
        #20000;
        err_total++;
        give_verdict();
    end
endmodule

// >>> hw/tension_framer_pkg.sv
// shared constants and types for the tension monitor message framer
package tension_framer_pkg;

    // ------------------------------------------------------------
    // configuration record offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_RESERVED_CFG  = 4'hc;
    localparam logic [3:0] OFS_STOP_FILTER   = 4'hd;
    localparam logic [3:0] OFS_RANGE_SELECT  = 4'he;
    localparam logic [3:0] OFS_CFG_CHECKSUM  = 4'hf;

    // ------------------------------------------------------------
    // power-on values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RESERVED_CFG  = 8'h00;
    localparam logic [7:0] RST_STOP_FILTER   = 8'h01;
    localparam logic [7:0] RST_RANGE_SELECT  = 8'h05;
    localparam logic [7:0] RST_CFG_CHECKSUM  = 8'hfb;
    localparam logic [7:0] RST_EVENT_BYTE    = 8'h00;

    // ------------------------------------------------------------
    // range select field and clamp
    // ------------------------------------------------------------
    localparam int         RANGE_SEL_LSB     = 0;
    localparam int         RANGE_SEL_W       = 5;
    localparam logic [4:0] RANGE_SEL_MAX     = 5'h0c;
    localparam int         RANGE_STEP_SHIFT  = 7;
    localparam int         RANGE_TOP_W       = 12;

    // ------------------------------------------------------------
    // first event byte layout
    // ------------------------------------------------------------
    localparam int TEN_HI_LSB      = 0;
    localparam int TEN_HI_W        = 4;
    localparam int BIT_BELOW_STOP  = 4;
    localparam int BIT_ABOVE_STOP  = 5;
    localparam int BIT_BELOW_IND   = 6;
    localparam int BIT_ABOVE_IND   = 7;
    localparam int TENSION_W       = 12;
    localparam int MSG_BYTES       = 3;

    // one seam result from the measuring side
    typedef struct packed {
        logic [TENSION_W-1:0] tension;
        logic                 below_stop;
        logic                 above_stop;
        logic                 below_ind;
        logic                 above_ind;
    } seam_result_s;

    // the three-byte runtime event message
    typedef struct packed {
        logic [7:0] flags_tension_high;
        logic [7:0] tension_low;
        logic [7:0] checksum;
    } event_msg_s;

endpackage

// >>> hw/tension_monitor_message_framer.sv
// record tail registers and runtime event message framing
`timescale 1ns/1ps

module tension_monitor_message_framer
    import tension_framer_pkg::*;
(
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    // configuration record access from the serial side
    input  wire logic                   cfg_wr,
    input  wire logic                   cfg_rd,
    input  wire logic [3:0]             cfg_addr,
    input  wire logic [7:0]             cfg_wdata,
    output logic      [7:0]             cfg_rdata_q,
    output logic                        cfg_rvalid_q,
    // carry-free sum of record bytes 0 to 11
    input  wire logic [7:0]             head_sum,
    output logic                        cfg_sum_ok_q,
    output logic [7:0]                  cfg_sum_expect_q,
    // operating settings
    output logic [RANGE_TOP_W-1:0]      range_top_q,
    output logic [7:0]                  stop_filter_q,
    // seam results
    input  wire logic                   seam_done,
    input  wire seam_result_s           seam_result,
    output event_msg_s                  event_msg_q,
    // event byte stream to the serial side
    output logic [7:0]                  tx_data_q,
    output logic                        tx_valid_q,
    input  wire logic                   tx_ready
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // two's complement of an eight-bit sum; 256 wraps to zero
    function automatic logic [7:0] csum8(input logic [7:0] sum);
        csum8 = 8'(8'h00 - sum);
    endfunction

    // stop filter qualification: count of consecutive seams
    function automatic logic [7:0] seam_count(input logic [7:0] cnt, input logic hit);
        if (!hit) begin
            seam_count = 8'h00;
        end else if (cnt == 8'hff) begin
            seam_count = cnt;
        end else begin
            seam_count = 8'(cnt + 8'h01);
        end
    endfunction

    // ------------------------------------------------------------
    // configuration record tail
    // ------------------------------------------------------------
    logic [7:0] reserved_cfg_byte_q;
    logic [7:0] reserved_cfg_byte_d;
    logic [7:0] stop_filter_setting_q;
    logic [7:0] stop_filter_setting_d;
    logic [7:0] range_select_q;
    logic [7:0] range_select_d;
    logic [7:0] config_checksum_q;
    logic [7:0] config_checksum_d;

    always_comb begin
        reserved_cfg_byte_d   = reserved_cfg_byte_q;
        stop_filter_setting_d = stop_filter_setting_q;
        range_select_d        = range_select_q;
        config_checksum_d     = config_checksum_q;
        if (cfg_wr) begin
            case (cfg_addr)
                OFS_RESERVED_CFG: begin
                    reserved_cfg_byte_d = cfg_wdata;
                end
                OFS_STOP_FILTER: begin
                    stop_filter_setting_d = cfg_wdata;
                end
                OFS_RANGE_SELECT: begin
                    range_select_d = cfg_wdata;
                end
                OFS_CFG_CHECKSUM: begin
                    config_checksum_d = cfg_wdata;
                end
                default: begin
                    reserved_cfg_byte_d = reserved_cfg_byte_q;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reserved_cfg_byte_q   <= RST_RESERVED_CFG;
            stop_filter_setting_q <= RST_STOP_FILTER;
            range_select_q        <= RST_RANGE_SELECT;
            config_checksum_q     <= RST_CFG_CHECKSUM;
        end else begin
            reserved_cfg_byte_q   <= reserved_cfg_byte_d;
            stop_filter_setting_q <= stop_filter_setting_d;
            range_select_q        <= range_select_d;
            config_checksum_q     <= config_checksum_d;
        end
    end

    // ------------------------------------------------------------
    // read back, range clamp and record sum
    // ------------------------------------------------------------
    logic [7:0]             cfg_rdata_d;
    logic                   cfg_rvalid_d;
    logic [4:0]             range_eff;
    logic [RANGE_TOP_W-1:0] range_top_d;
    logic [7:0]             tail_sum;
    logic                   cfg_sum_ok_d;
    logic [7:0]             cfg_sum_expect_d;

    always_comb begin
        // reads return the value written, not the clamped one
        case (cfg_addr)
            OFS_RESERVED_CFG: cfg_rdata_d = reserved_cfg_byte_q;
            OFS_STOP_FILTER:  cfg_rdata_d = stop_filter_setting_q;
            OFS_RANGE_SELECT: cfg_rdata_d = range_select_q;
            OFS_CFG_CHECKSUM: cfg_rdata_d = config_checksum_q;
            default:          cfg_rdata_d = 8'h00;
        endcase
        if (!cfg_rd) begin
            cfg_rdata_d = cfg_rdata_q;
        end
        cfg_rvalid_d = cfg_rd;

        range_eff = range_select_q[RANGE_SEL_LSB +: RANGE_SEL_W];
        if (range_eff > RANGE_SEL_MAX) begin
            range_eff = RANGE_SEL_MAX;
        end
        range_top_d = RANGE_TOP_W'(range_eff) << RANGE_STEP_SHIFT;

        tail_sum = 8'(head_sum + reserved_cfg_byte_q + stop_filter_setting_q + range_select_q);
        cfg_sum_expect_d = csum8(tail_sum);
        cfg_sum_ok_d     = (8'(tail_sum + config_checksum_q) == 8'h00);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rdata_q      <= 8'h00;
            cfg_rvalid_q     <= 1'b0;
            range_top_q      <= '0;
            stop_filter_q    <= RST_STOP_FILTER;
            cfg_sum_ok_q     <= 1'b0;
            cfg_sum_expect_q <= 8'h00;
        end else begin
            cfg_rdata_q      <= cfg_rdata_d;
            cfg_rvalid_q     <= cfg_rvalid_d;
            range_top_q      <= range_top_d;
            stop_filter_q    <= stop_filter_setting_q;
            cfg_sum_ok_q     <= cfg_sum_ok_d;
            cfg_sum_expect_q <= cfg_sum_expect_d;
        end
    end

    // ------------------------------------------------------------
    // stop filter and event message build
    // ------------------------------------------------------------
    logic [7:0] below_cnt_q;
    logic [7:0] below_cnt_d;
    logic [7:0] above_cnt_q;
    logic [7:0] above_cnt_d;
    event_msg_s event_msg_d;
    logic       below_stop_ok;
    logic       above_stop_ok;
    logic [7:0] byte_one;
    logic [7:0] byte_two;

    always_comb begin
        below_cnt_d = below_cnt_q;
        above_cnt_d = above_cnt_q;
        event_msg_d = event_msg_q;
        below_stop_ok = 1'b0;
        above_stop_ok = 1'b0;
        byte_one = 8'h00;
        byte_two = 8'h00;
        if (seam_done) begin
            below_cnt_d = seam_count(below_cnt_q, seam_result.below_stop);
            above_cnt_d = seam_count(above_cnt_q, seam_result.above_stop);
            // stop flag only after enough consecutive seams; zero disables
            below_stop_ok = (stop_filter_setting_q != 8'h00) &&
                            (below_cnt_d >= stop_filter_setting_q);
            above_stop_ok = (stop_filter_setting_q != 8'h00) &&
                            (above_cnt_d >= stop_filter_setting_q);
            byte_one[TEN_HI_LSB +: TEN_HI_W] = seam_result.tension[TENSION_W-1 -: TEN_HI_W];
            byte_one[BIT_BELOW_STOP] = below_stop_ok;
            byte_one[BIT_ABOVE_STOP] = above_stop_ok;
            byte_one[BIT_BELOW_IND]  = seam_result.below_ind;
            byte_one[BIT_ABOVE_IND]  = seam_result.above_ind;
            byte_two = seam_result.tension[7:0];
            event_msg_d.flags_tension_high = byte_one;
            event_msg_d.tension_low        = byte_two;
            event_msg_d.checksum           = csum8(8'(byte_one + byte_two));
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            below_cnt_q <= 8'h00;
            above_cnt_q <= 8'h00;
            event_msg_q <= {RST_EVENT_BYTE, RST_EVENT_BYTE, RST_EVENT_BYTE};
        end else begin
            below_cnt_q <= below_cnt_d;
            above_cnt_q <= above_cnt_d;
            event_msg_q <= event_msg_d;
        end
    end

    // ------------------------------------------------------------
    // byte transmitter
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_LOAD,
        TX_SEND
    } tx_state_e;

    tx_state_e  tx_state_q;
    tx_state_e  tx_state_d;
    event_msg_s tx_frame_q;
    event_msg_s tx_frame_d;
    logic [1:0] tx_idx_q;
    logic [1:0] tx_idx_d;
    logic [7:0] tx_data_d;
    logic       tx_valid_d;
    logic       pend_q;
    logic       pend_d;

    always_comb begin
        tx_state_d = tx_state_q;
        tx_frame_d = tx_frame_q;
        tx_idx_d   = tx_idx_q;
        tx_data_d  = tx_data_q;
        tx_valid_d = tx_valid_q;
        // a seam during a frame is remembered; newest message wins
        pend_d     = pend_q | seam_done;
        case (tx_state_q)
            TX_IDLE: begin
                if (pend_q) begin
                    tx_state_d = TX_LOAD;
                end
            end
            TX_LOAD: begin
                pend_d     = seam_done;
                tx_frame_d = event_msg_q;
                tx_idx_d   = 2'd0;
                tx_data_d  = event_msg_q.flags_tension_high;
                tx_valid_d = 1'b1;
                tx_state_d = TX_SEND;
            end
            TX_SEND: begin
                if (tx_ready) begin
                    if (tx_idx_q == 2'(MSG_BYTES - 1)) begin
                        tx_valid_d = 1'b0;
                        tx_state_d = TX_IDLE;
                    end else begin
                        tx_idx_d = 2'(tx_idx_q + 2'd1);
                        if (tx_idx_q == 2'd0) begin
                            tx_data_d = tx_frame_q.tension_low;
                        end else begin
                            tx_data_d = tx_frame_q.checksum;
                        end
                    end
                end
            end
            default: begin
                tx_state_d = TX_IDLE;
                tx_valid_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_state_q <= TX_IDLE;
            tx_frame_q <= '0;
            tx_idx_q   <= 2'd0;
            tx_data_q  <= 8'h00;
            tx_valid_q <= 1'b0;
            pend_q     <= 1'b0;
        end else begin
            tx_state_q <= tx_state_d;
            tx_frame_q <= tx_frame_d;
            tx_idx_q   <= tx_idx_d;
            tx_data_q  <= tx_data_d;
            tx_valid_q <= tx_valid_d;
            pend_q     <= pend_d;
        end
    end

endmodule
